// *** logic/c5t_params.svh ***
// Purpose: Offsets, reset values and field positions of the cell-5 trim bank
// Assumes: Register index times four is the AXI byte address
// Notes: Definitions only
`ifndef C5T_PARAMS_SVH
`define C5T_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define C5T_IDX_WORD1 10'h089
`define C5T_IDX_WORD2 10'h08a
`define C5T_IDX_WORD3 10'h08b
`define C5T_IDX_WORD4 10'h08c
`define C5T_IDX_WORD5 10'h08d
`define C5T_IDX_WORD6 10'h08e
`define C5T_IDX_WORD7 10'h08f
`define C5T_IDX_WORD8 10'h090
`define C5T_IDX_WORD9 10'h091

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define C5T_BYTE_RST 8'h00
`define C5T_RESP_OKAY 2'h0
`define C5T_RESP_SLVERR 2'h2
`define C5T_BYTE_W 8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define C5T_SPARE_BIT 7

`endif

// *** logic/c5t_pkg.sv ***
// Purpose: Types shared by the cell-5 trim bank
// Assumes: Coefficient widths as packed across the bank
// Notes: Offset order-zero coefficient is 14 bits; only its low nibble is readable over the bus
package c5t_pkg;

  typedef struct packed {
    logic [14:0] gain_coeff_order0;
    logic [13:0] gain_coeff_order1;
    logic [13:0] gain_coeff_order2;
    logic [11:0] gain_coeff_order3;
    logic [11:0] gain_coeff_order4;
    logic [13:0] offset_coeff_order0;
  } c5t_coeff_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } c5t_rd_byte_t;

endpackage

// *** logic/c5t_trim_bank.sv ***
// Purpose: Read-only AXI4-Lite bank of cell-5 ADC gain trim coefficients
// Assumes: Trim values arrive from a fuse loader on the same clock
// Notes: One read and one write in flight; reads answer one cycle after the take
//   Writes to bank words answer OKAY and store nothing; others answer SLVERR
//   Unmapped reads return zero data
//   The trim port is the only way into the store
//   Coefficients change only in reset or on an aclk edge with trim_load high
//
// Behaviour
// - 0x8A bits 6:0 give order0 bits 14:8
// - 0x8A bit 7 gives order1 bit 0
// - 0x8B gives order1 bits 8:1
// - 0x8C bits 4:0 give order1 bits 13:9
// - 0x8C bits 7:5 give order2 bits 2:0
// - 0x8D gives order2 bits 10:3
// - 0x8E bits 2:0 give order2 bits 13:11
// - 0x8E bits 7:3 give order3 bits 4:0
// - 0x8F bits 6:0 order3 11:5, spare bit 7
// - 0x90 gives order4 bits 7:0
// - 0x89 gives order0 bits 7:0
// - 0x91 bits 3:0 give order4 bits 11:8
// - 0x91 bits 7:4 give offset0 bits 3:0
`timescale 1ns/1ps
`include "c5t_params.svh"

module c5t_trim_bank
  import c5t_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,

  // Trim loader
  input wire logic trim_load,
  input wire c5t_coeff_t trim_in,

  // Coefficients to the measurement path
  output c5t_coeff_t coeff,

  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,

  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,

  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,

  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,

  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------
  // The low two address bits are ignored: each register is one aligned word
  function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] addr);
    return 10'(addr[ADDR_W-1:2]);
  endfunction

  // Write and read channels share this so their responses always agree
  function automatic logic bank_hit(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = word_index(addr);
    return (idx >= `C5T_IDX_WORD1) && (idx <= `C5T_IDX_WORD9);
  endfunction

  function automatic logic [1:0] resp_code(input logic hit);
    return hit ? `C5T_RESP_OKAY : `C5T_RESP_SLVERR;
  endfunction

  // ----------------------------------------------------------------
  // Register bytes
  // ----------------------------------------------------------------
  function automatic c5t_rd_byte_t read_byte(input logic [ADDR_W-1:0] addr, input c5t_coeff_t c);
    logic [9:0] idx;
    c5t_rd_byte_t r;
    idx = word_index(addr);
    r.valid = bank_hit(addr);
    r.data = `C5T_BYTE_RST;
    if (idx == `C5T_IDX_WORD1) begin
      r.data = c.gain_coeff_order0[7:0];
    end else if (idx == `C5T_IDX_WORD2) begin
      r.data[6:0] = c.gain_coeff_order0[14:8];
      r.data[7] = c.gain_coeff_order1[0];
    end else if (idx == `C5T_IDX_WORD3) begin
      r.data = c.gain_coeff_order1[8:1];
    end else if (idx == `C5T_IDX_WORD4) begin
      r.data[4:0] = c.gain_coeff_order1[13:9];
      r.data[7:5] = c.gain_coeff_order2[2:0];
    end else if (idx == `C5T_IDX_WORD5) begin
      r.data = c.gain_coeff_order2[10:3];
    end else if (idx == `C5T_IDX_WORD6) begin
      r.data[2:0] = c.gain_coeff_order2[13:11];
      r.data[7:3] = c.gain_coeff_order3[4:0];
    end else if (idx == `C5T_IDX_WORD7) begin
      r.data[6:0] = c.gain_coeff_order3[11:5];
      r.data[`C5T_SPARE_BIT] = 1'b0;
    end else if (idx == `C5T_IDX_WORD8) begin
      r.data = c.gain_coeff_order4[7:0];
    end else if (idx == `C5T_IDX_WORD9) begin
      r.data[3:0] = c.gain_coeff_order4[11:8];
      r.data[7:4] = c.offset_coeff_order0[3:0];
    end else begin
      r.valid = 1'b0;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Coefficient store
  // ----------------------------------------------------------------
  c5t_coeff_t coeff_q, coeff_d;

  // Only the loader and reset change the store; the bus has no path into it
  always_comb begin
    coeff_d = coeff_q;
    if (trim_load) begin
      coeff_d = trim_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coeff_q <= '0;
    end else begin
      coeff_q <= coeff_d;
    end
  end

  // ----------------------------------------------------------------
  // Coefficient output
  // ----------------------------------------------------------------
  // The measurement path sees the same flops that the bus reads back
  assign coeff = coeff_q;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic aw_got_q, aw_got_d;
  logic w_got_q, w_got_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic aw_take, w_take, wr_fire, b_done;
  logic [ADDR_W-1:0] wr_addr;

  // Readies drop while a response waits, so at most one write is ever in flight
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  // Address and data come in either order; the write fires once both are in
  assign wr_fire = (aw_got_q || aw_take) && (w_got_q || w_take);
  assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
  assign b_done = bvalid_q && s_axi_bready;

  // Channel holding: remember whichever half arrived first
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    if (aw_take) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (w_take) begin
      w_got_d = 1'b1;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  // Data and strobes are dropped: a bank hit answers OKAY and stores nothing
  always_comb begin
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d = resp_code(bank_hit(wr_addr));
    end
    if (b_done) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `C5T_RESP_OKAY;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic ar_take, r_done;
  c5t_rd_byte_t rd_hit;

  // A new address waits until the previous answer has been taken
  assign s_axi_arready = !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_done = rvalid_q && s_axi_rready;
  assign rd_hit = read_byte(s_axi_araddr, coeff_q);

  always_comb begin
    rvalid_d = rvalid_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
    end else if (r_done) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Data is captured at the take so a trim load mid-answer cannot tear it
  // An unmapped address reads as zero so software never sees stale bytes
  always_comb begin
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_take) begin
      rdata_d = {24'h00_0000, rd_hit.data};
      rresp_d = resp_code(rd_hit.valid);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 32'h0000_0000;
      rresp_q <= `C5T_RESP_OKAY;
    end else begin
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

// *** sim/c5t_trim_bank_asserts.sv ***
// Purpose: Port assertions for the cell-5 trim bank
// Assumes: No trim load overlaps a read
// Notes: Bound to every bank instance
`timescale 1ns/1ps
module c5t_trim_bank_asserts
  import c5t_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and loader
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trim_load,
  input wire c5t_coeff_t coeff,
  // Bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // Bank seen as one bit stream
  // ----
  logic [71:0] bank;
  logic [9:0] ix;
  logic [31:0] exp_rd;
  assign bank = {coeff.offset_coeff_order0[3:0], coeff.gain_coeff_order4, 1'b0, coeff.gain_coeff_order3,
    coeff.gain_coeff_order2, coeff.gain_coeff_order1, coeff.gain_coeff_order0};
  assign ix = 10'(s_axi_araddr[ADDR_W-1:2]) - 10'h089;
  assign exp_rd = (ix < 10'h9) ? {24'h0, bank[8*ix +: 8]} : 32'h0;
  sequence s_take;
    s_axi_arvalid && s_axi_arready && !trim_load;
  endsequence
  a_rd_map: assert property (s_take |=> s_axi_rdata == $past(exp_rd))
    else $error("read data differs from bank");
  a_rd_resp: assert property (s_take |=> s_axi_rresp == ($past(ix) < 10'h9 ? 2'h0 : 2'h2))
    else $error("read response wrong");
  a_rd_lat: assert property (s_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while answering");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_ro_keep: assert property (!trim_load |=> $stable(coeff))
    else $error("coefficients changed without load");
  a_rst_zero: assert property ($rose(aresetn) |-> coeff == '0)
    else $error("coefficients not zero after reset");
endmodule
bind c5t_trim_bank c5t_trim_bank_asserts #(.ADDR_W(ADDR_W)) c5t_trim_bank_asserts_i (.aclk, .aresetn,
  .trim_load, .coeff, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_bvalid, .s_axi_bready);

// *** sim/c5t_trim_bank_tb_top.sv ***
// Purpose: Self-checking bench for the cell-5 trim bank
// Assumes: Reads never overlap a trim load
// Notes: Write data and trims come from a fixed-seed shift register, save fixed trims in rounds 0, 1, 2 and 12
`timescale 1ns/1ps
module c5t_trim_bank_tb_top
  import c5t_pkg::*;
;
  logic aclk, aresetn, trim_load, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  c5t_coeff_t trim_in, coeff;
  int fails, n_compared, cyc;
  c5t_trim_bank c5t_trim_bank_i (.aclk, .aresetn, .trim_load, .trim_in, .coeff, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_rd(c5t_coeff_t c, logic [9:0] ix);
    logic [71:0] b;
    b = {c.offset_coeff_order0[3:0], c.gain_coeff_order4, 1'b0, c.gain_coeff_order3, c.gain_coeff_order2,
      c.gain_coeff_order1, c.gain_coeff_order0};
    return (ix inside {[10'h089:10'h091]}) ? {24'h0, b[8*(ix-10'h089) +: 8]} : 32'h0;
  endfunction
  task automatic cmp(input logic [80:0] got, input logic [80:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each channel drops at its own take; odd indices raise the answer ready late so held answers occur
  task automatic xfer(input logic w, input logic [9:0] ix, output logic [31:0] d, output logic [1:0] r);
    logic aw_p, w_p, ar_p, done;
    {aw_p, w_p, ar_p, done} = {w, w, !w, 1'b0};
    {s_axi_awaddr, s_axi_araddr} <= {2{ix, 2'b00}};
    s_axi_wdata <= seed;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    {s_axi_bready, s_axi_rready} <= {w, !w} & {2{!ix[0]}};
    while (!done) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (ar_p && s_axi_arready) begin
        ar_p = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (w ? s_axi_bvalid : s_axi_rvalid) begin
        done = w ? s_axi_bready : s_axi_rready;
        d = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
        if (!done) {s_axi_bready, s_axi_rready} <= {w, !w};
      end
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    c5t_coeff_t c;
    logic [31:0] d;
    logic [1:0] r;
    logic [9:0] wi;
    seed = 32'h51a9_9acc;
    {aresetn, trim_load, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {trim_in, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    // Round 0 follows power-up, round 12 a reset in mid-run
    for (int k = 0; k < 13; k++) begin
      repeat (3) begin
        seed = lfsr(seed);
        c = {c[48:0], seed};
      end
      if (k == 1) c = '1;
      if (k == 2) c = {27{3'b101}};
      if (k % 12 == 0) c = '0;
      aresetn <= k != 12;
      trim_in <= c;
      trim_load <= k % 12 != 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      trim_load <= 1'b0;
      wi = 10'h088 + 10'(seed % 11);
      xfer(1'b1, wi, d, r);
      cmp(r, (wi inside {[10'h089:10'h091]}) ? 2'h0 : 2'h2);
      cmp(coeff, c);
      for (int i = 'h88; i <= 'h92; i++) begin
        xfer(1'b0, 10'(i), d, r);
        cmp({d, r}, {exp_rd(c, 10'(i)), (i inside {['h89:'h91]}) ? 2'h0 : 2'h2});
      end
    end
    report_and_stop();
  end
endmodule
